// ---- design/ess_emu_support.sv ----
`timescale 1ns/10ps
module ess_emu_support
	import ess_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cacheDisableInN,
	input  wire logic        translationDisableInN,
	input  wire logic        icacheEnable,
	input  wire logic        dcacheEnable,
	input  wire logic        icacheHitRaw,
	input  wire logic        dcacheHitRaw,
	input  wire logic        cacheInhibitInN,
	input  wire logic        cacheInhibitOutN,
	input  wire logic        translationValid,
	input  wire logic [31:0] logicalAddr,
	input  wire logic [31:0] translatedAddr,
	input  wire logic        flowChange,
	input  wire logic        srModify,
	input  wire logic        evBoundary,
	input  wire logic        evException,
	input  wire logic        evHalted,
	output logic             icacheHit,
	output logic             dcacheHit,
	output logic             icacheCachable,
	output logic             dcacheCachable,
	output logic [31:0]      physicalAddr,
	output logic             translationBypass,
	output logic             pipeFlush,
	output logic             pipelineRefillN,
	output logic             seqStatusN
);
	import ess_pkg::*;

	logic       cdisMeta_q, cdisSync_q, mdisMeta_q, mdisSync_q;
	logic       cacheOff;
	ess_stat_t  stat_q;
	logic [1:0] statCnt_q;
	logic [1:0] statLen_d;

	// every assertion below samples on the processor clock
	default clocking cbMain @(posedge clk);
	endclocking
	default disable iff (rst);

	// two-stage synchronisers for the emulator inputs
	always_ff @(posedge clk) begin
		if (rst) begin
			cdisMeta_q <= 1'h0;
			cdisSync_q <= 1'h0;
			mdisMeta_q <= 1'h0;
			mdisSync_q <= 1'h0;
		end else begin
			cdisMeta_q <= ~cacheDisableInN;
			cdisSync_q <= cdisMeta_q;
			mdisMeta_q <= ~translationDisableInN;
			mdisSync_q <= mdisMeta_q;
		end
	end

	// disable gates hits and cachability; cache contents are never touched here
	assign cacheOff = cdisSync_q;

	// hit gating and cachability for the next access
	always_ff @(posedge clk) begin
		if (rst) begin
			icacheHit      <= 1'h0;
			dcacheHit      <= 1'h0;
			icacheCachable <= 1'h0;
			dcacheCachable <= 1'h0;
		end else begin
			icacheHit <= icacheHitRaw & icacheEnable & ~cacheOff;
			dcacheHit <= dcacheHitRaw & dcacheEnable & ~cacheOff;
			icacheCachable <= icacheEnable & ~cacheOff & cacheInhibitInN
				& cacheInhibitOutN & translationValid;
			dcacheCachable <= dcacheEnable & ~cacheOff & cacheInhibitInN
				& cacheInhibitOutN & translationValid;
		end
	end

	// translation bypass: logical address used as physical
	always_ff @(posedge clk) begin
		if (rst) begin
			physicalAddr      <= 32'h0000_0000;
			translationBypass <= 1'h0;
		end else begin
			translationBypass <= mdisSync_q;
			physicalAddr <= mdisSync_q ? logicalAddr : translatedAddr;
		end
	end

	// pipeline flush and refill indication
	always_ff @(posedge clk) begin
		if (rst) begin
			pipeFlush       <= 1'h0;
			pipelineRefillN <= PIN_NEGATED;
		end else begin
			pipeFlush       <= flowChange | srModify;
			pipelineRefillN <= ~(flowChange | srModify);
		end
	end

	// pulse length chosen by event priority: halt, exception, boundary
	always_comb begin
		statLen_d = STAT_LEN_BOUNDARY;
		if (evHalted) begin
			statLen_d = STAT_LEN_HALTED;
		end else if (evException) begin
			statLen_d = STAT_LEN_EXCEPTION;
		end
	end

	// status pulse generator, at least two negated clocks (gap, then idle) between pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_q     <= ST_IDLE;
			statCnt_q  <= 2'h0;
			seqStatusN <= PIN_NEGATED;
		end else begin
			case (stat_q)
				ST_IDLE: begin
					if (evHalted | evException | evBoundary) begin
						stat_q     <= ST_PULSE;
						statCnt_q  <= statLen_d - 2'h1;
						seqStatusN <= 1'h0;
					end
				end
				ST_PULSE: begin
					if (statCnt_q == 2'h0) begin
						stat_q     <= ST_GAP;
						seqStatusN <= PIN_NEGATED;
					end else begin
						statCnt_q <= statCnt_q - 2'h1;
					end
				end
				default: begin
					stat_q <= ST_IDLE;
				end
			endcase
		end
	end

	// event starts seen in idle, by priority, and the pulse shapes
	sequence s_halt_go;
		stat_q == ST_IDLE && evHalted;
	endsequence
	sequence s_exc_go;
		stat_q == ST_IDLE && !evHalted && evException;
	endsequence
	sequence s_bnd_go;
		stat_q == ST_IDLE && !evHalted && !evException && evBoundary;
	endsequence
	sequence s_pulse1;
		!seqStatusN ##1 seqStatusN;
	endsequence
	sequence s_pulse2;
		!seqStatusN [*2] ##1 seqStatusN;
	endsequence
	sequence s_pulse3;
		!seqStatusN [*3] ##1 seqStatusN;
	endsequence

	// status low time matches the event class
	a_stat_halt_len: assert property (s_halt_go |=> s_pulse3)
		else $error("halt status pulse length wrong");
	a_stat_exc_len: assert property (s_exc_go |=> s_pulse2)
		else $error("exception status pulse length wrong");
	a_stat_bnd_len: assert property (s_bnd_go |=> s_pulse1)
		else $error("boundary status pulse length wrong");
	// gap cycle stays negated and returns to idle
	a_stat_gap: assert property (stat_q == ST_GAP
		|-> seqStatusN ##1 (stat_q == ST_IDLE))
		else $error("status gap not honoured");

	// emulator cache disable gates hits and cachability
	a_cache_disable_in_no_hit: assert property (cdisSync_q
		|=> !icacheHit && !dcacheHit && !icacheCachable)
		else $error("cache hit while disabled");
	a_cache_disable_in_dca: assert property (cdisSync_q |=> !dcacheCachable)
		else $error("data access cachable while disabled");
	a_cache_disable_in_resume: assert property (!cdisSync_q
		&& icacheHitRaw && icacheEnable |=> icacheHit)
		else $error("hit lost after cache disable negated");

	// any missing condition makes the access uncachable
	a_ica_gate: assert property (!icacheEnable || !cacheInhibitInN
		|| !cacheInhibitOutN || !translationValid |=> !icacheCachable)
		else $error("icache cachable with a condition missing");
	a_dca_gate: assert property (!dcacheEnable || !cacheInhibitInN
		|| !cacheInhibitOutN || !translationValid |=> !dcacheCachable)
		else $error("dcache cachable with a condition missing");

	// translation bypass follows the synchronised disable
	a_mmu_bypass: assert property (mdisSync_q
		|=> physicalAddr == $past(logicalAddr))
		else $error("translation not bypassed");
	a_mmu_resume: assert property (!mdisSync_q
		|=> physicalAddr == $past(translatedAddr))
		else $error("translation not used when enabled");
	a_byp_flag: assert property (mdisSync_q |=> translationBypass)
		else $error("bypass flag missing");
	a_byp_clear: assert property (!mdisSync_q
		|=> !translationBypass)
		else $error("bypass flag stuck");

	// refill pin follows the flush causes one clock later
	a_refill_pulse: assert property (flowChange || srModify
		|=> !pipelineRefillN && pipeFlush)
		else $error("refill not signalled");
	a_refill_idle: assert property (!flowChange && !srModify
		|=> pipelineRefillN && !pipeFlush)
		else $error("refill without a cause");

	// both disable pins reach the gating through two flops
	a_cache_disable_in_sync: assert property (!cacheDisableInN ##1
		!cacheDisableInN |=> cdisSync_q)
		else $error("cache disable not sampled");
	a_cache_disable_in_release: assert property (cacheDisableInN ##1
		cacheDisableInN |=> !cdisSync_q)
		else $error("cache disable not released");
	a_mdis_sync: assert property (!translationDisableInN ##1
		!translationDisableInN |=> mdisSync_q)
		else $error("translation disable not sampled");
endmodule

// ---- design/ess_pkg.sv ----
package ess_pkg;
	// microsequencer status pulse lengths in clocks
	localparam logic [1:0] STAT_LEN_BOUNDARY  = 2'h1;
	localparam logic [1:0] STAT_LEN_EXCEPTION = 2'h2;
	localparam logic [1:0] STAT_LEN_HALTED    = 2'h3;
	// reset values of the active-low outputs (negated)
	localparam logic       PIN_NEGATED        = 1'h1;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_GAP
	} ess_stat_t;
endpackage

// ---- tb/ess_emu_model.sv ----
`timescale 1ns/10ps
// emulator side: drives both disable pins off the falling edge
module ess_emu_model (
	input  wire logic clk,
	input  wire logic cacheOff,
	input  wire logic mmuOff,
	output logic      cacheDisableInN,
	output logic      translationDisableInN
);
	initial begin
		cacheDisableInN = 1'h1;
		translationDisableInN = 1'h1;
	end
	// a pin reads low while its request is held
	always @(negedge clk) begin
		cacheDisableInN <= ~cacheOff;
		translationDisableInN <= ~mmuOff;
	end
endmodule

// ---- tb/test_ess_emu_support.sv ----
`timescale 1ns/10ps
module test_ess_emu_support;
	import ess_pkg::*;
	logic clk, rst, cOff, mOff, cdN, tdN, icEn, dcEn, icRaw, dcRaw;
	logic ciN, coN, tVal, flow, srMod, evB, evE, evH;
	logic icHit, dcHit, icCa, dcCa, byp, flush, refN, statN;
	logic [31:0] lAddr, tAddr, pAddr;
	int mismatches, num_checks, cnt;
	// free-running clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	ess_emu_model u_ess_emu_model (.clk(clk), .cacheOff(cOff),
		.mmuOff(mOff), .cacheDisableInN(cdN), .translationDisableInN(tdN));
	ess_emu_support u_ess_emu_support (.clk(clk), .rst(rst),
		.cacheDisableInN(cdN), .translationDisableInN(tdN),
		.icacheEnable(icEn), .dcacheEnable(dcEn), .icacheHitRaw(icRaw),
		.dcacheHitRaw(dcRaw), .cacheInhibitInN(ciN),
		.cacheInhibitOutN(coN), .translationValid(tVal),
		.logicalAddr(lAddr), .translatedAddr(tAddr), .flowChange(flow),
		.srModify(srMod), .evBoundary(evB), .evException(evE),
		.evHalted(evH), .icacheHit(icHit), .dcacheHit(dcHit),
		.icacheCachable(icCa), .dcacheCachable(dcCa),
		.physicalAddr(pAddr), .translationBypass(byp), .pipeFlush(flush),
		.pipelineRefillN(refN), .seqStatusN(statN));
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task stop_test;
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// disable gates hits; entries serve again once released
	task t_cache;
		cOff = 1'h1;
		cyc(5);
		chk("icHit", 0, icHit);
		chk("dcCa", 0, dcCa);
		cOff = 1'h0;
		cyc(5);
		chk("dcHit", 1, dcHit);
		chk("icHit", 1, icHit);
		ciN = 1'h0;
		cyc(2);
		chk("icCa", 0, icCa);
		{ciN, coN} = 2'h2;
		cyc(2);
		chk("dcCa", 0, dcCa);
		{coN, tVal} = 2'h2;
		cyc(2);
		chk("icCa", 0, icCa);
		tVal = 1'h1;
		cyc(2);
		chk("icCa", 1, icCa);
	endtask
	// translation bypass and return
	task t_mmu;
		mOff = 1'h1;
		cyc(5);
		chk("pAddr", lAddr, pAddr);
		chk("byp", 1, byp);
		mOff = 1'h0;
		cyc(5);
		chk("pAddr", tAddr, pAddr);
		chk("byp", 0, byp);
	endtask
	// mid-run reset negates every output, then work resumes
	task t_reset;
		{rst, flow, evH} = 3'h7;
		cyc(2);
		chk("refN", 1, refN);
		chk("flush", 0, flush);
		chk("statN", 1, statN);
		chk("pAddr", 0, pAddr);
		chk("icCa", 0, icCa);
		{rst, flow, evH} = 3'h0;
		cyc(1);
		chk("pAddr", tAddr, pAddr);
		chk("icHit", 1, icHit);
		chk("statN", 1, statN);
		cyc(1);
	endtask
	// one flush cause held for one cycle
	task t_refill(input logic [1:0] cause);
		{flow, srMod} = cause;
		cyc(1);
		chk("refN", 0, refN);
		chk("flush", 1, flush);
		{flow, srMod} = 2'h0;
		cyc(1);
		chk("refN", 1, refN);
		chk("flush", 0, flush);
	endtask
	// count low cycles of the status pulse
	task t_stat(input logic [2:0] ev, input logic [1:0] len);
		{evH, evE, evB} = ev;
		cyc(1);
		{evH, evE, evB} = 3'h0;
		cnt = 0;
		for (int i = 0; i < 8; i++) begin
			if (statN === 1'h0)
				cnt++;
			cyc(1);
		end
		chk("statLen", {30'h0, len}, cnt);
	endtask
	initial begin
		{rst, icEn, dcEn, icRaw, dcRaw, ciN, coN, tVal} = 8'hFF;
		{cOff, mOff, flow, srMod, evB, evE, evH} = 7'h00;
		lAddr = 32'h1234_5678;
		tAddr = 32'h00AB_CDEF;
		cyc(8);
		rst = 1'h0;
		cyc(2);
		t_cache;
		t_mmu;
		t_refill(2'h2);
		t_refill(2'h1);
		t_reset;
		t_stat(3'h4, STAT_LEN_HALTED);
		t_stat(3'h2, STAT_LEN_EXCEPTION);
		t_stat(3'h1, STAT_LEN_BOUNDARY);
		stop_test;
	end
endmodule
